// ---- ils_consts.vh ----
`ifndef ILS_CONSTS_VH
`define ILS_CONSTS_VH

// Register byte addresses
`define ILS_ADDR_ERR_LINE_SEL 32'hffbff028
`define ILS_ADDR_STAT_LINE_SEL 32'hffbff02c
`define ILS_ADDR_ERR_EN_SET 32'hffbff030
`define ILS_ADDR_ERR_EN_RESET 32'hffbff034
`define ILS_ADDR_EVT_STATUS 32'hffbff040
`define ILS_ADDR_EVT_ENABLE 32'hffbff044
`define ILS_ADDR_EVT_CLEAR 32'hffbff048

// Implemented bit masks, reserved bits are zero
`define ILS_STAT_SEL_MASK 32'h0303ffff
`define ILS_ERR_MASK 32'h07070fff
`define ILS_EVT_MASK 32'h00000003

// Reset values
`define ILS_STAT_SEL_RESET 32'h0303ffff
`define ILS_ERR_SEL_RESET 32'h00000000
`define ILS_ERR_EN_RESET_VAL 32'h00000000
`define ILS_EVT_RESET 32'h00000000

// Status line select field positions
`define ILS_TEST_SYMBOL_B_LINE 25
`define ILS_WAKE_PATTERN_B_LINE 24
`define ILS_TEST_SYMBOL_A_LINE 17
`define ILS_WAKE_PATTERN_A_LINE 16

// Error enable field positions
`define ILS_BOUNDARY_TX_B_ENABLE 26
`define ILS_LATE_TX_B_ENABLE 25
`define ILS_ERROR_DETECT_B_ENABLE 24
`define ILS_BOUNDARY_TX_A_ENABLE 18
`define ILS_LATE_TX_A_ENABLE 17
`define ILS_ERROR_DETECT_A_ENABLE 16

// Block event bit positions
`define ILS_EVT_UNMAPPED 0
`define ILS_EVT_RESERVED_WRITE 1

// AHB encodings
`define ILS_HRESP_OKAY 1'b0

`endif

// ---- ils_line_router.v ----
`timescale 1ns/1ps
`default_nettype none

module ils_line_router #(
  parameter WIDTH = 32
) (
  input wire [WIDTH-1:0] flags,
  input wire [WIDTH-1:0] enables,
  input wire [WIDTH-1:0] line_sel,
  output wire hit_zero,
  output wire hit_one
);

  wire [WIDTH-1:0] live;
  wire [WIDTH-1:0] to_zero;
  wire [WIDTH-1:0] to_one;

  // Per-source gating and steering to one of two lines
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_src
      assign live[i] = flags[i] & enables[i]; // RULE_07
      assign to_zero[i] = live[i] & ~line_sel[i]; // RULE_02
      assign to_one[i] = live[i] & line_sel[i]; // RULE_01
    end
  endgenerate

  // Any live source on each line
  assign hit_zero = |to_zero; // RULE_14
  assign hit_one = |to_one; // RULE_14

endmodule

`default_nettype wire

// ---- ils_irq_line_select.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ils_consts.vh"

// What this block does
// RULE_01: Each status source goes to exactly one of two interrupt outputs.
// RULE_02: Select bit 0 steers to output zero, 1 to output one.
// RULE_03: Status line select bits reset to 1, register reads 0303ffff.
// RULE_04: Channel B selects at bits 25,24, channel A at 17,16, others 15..0.
// RULE_05: Reserved bits of both registers read as zero.
// RULE_06: Software writes zero to every reserved bit.
// RULE_07: An error flag interrupts only while its enable bit is set.
// RULE_08: Writing 1 to enable set register sets that enable; 0 leaves it.
// RULE_09: Reading enable set register returns current enables, 1 enabled.
// RULE_10: Channel B enables at 26..24, channel A at 18..16, general at 11..0.
// RULE_11: All error enables clear at reset, register reads zero.
// RULE_12: Enable reset register shares state; writing 1 clears that enable.
// RULE_13: Each error flag is routed to one output by its line select bit.
// RULE_14: Output high while any routed flag is set and enabled.
module ils_irq_line_select (
  input wire CLOCK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [31:0] STATUS_IRQ_FLAGS,
  input wire [31:0] STATUS_IRQ_ENABLES,
  input wire [31:0] ERROR_IRQ_FLAGS,
  output reg IRQ_OUT_ZERO,
  output reg IRQ_OUT_ONE,
  output reg BLOCK_IRQ
);

  reg [31:0] stat_sel_reg;
  reg [31:0] stat_sel_next;
  reg [31:0] err_sel_reg;
  reg [31:0] err_sel_next;
  reg [31:0] err_en_reg;
  reg [31:0] err_en_next;
  reg [31:0] evt_status_reg;
  reg [31:0] evt_status_next;
  reg [31:0] evt_enable_reg;
  reg [31:0] evt_enable_next;
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;
  reg [31:0] rd_next;
  reg [31:0] evt_set;
  reg [31:0] evt_clr;
  wire addr_phase;
  wire stat_hit_zero;
  wire stat_hit_one;
  wire err_hit_zero;
  wire err_hit_one;
  wire wr_phase;
  wire rd_phase;
  wire [31:0] stat_flags_impl;
  wire [31:0] err_flags_impl;

  // Both routers cover a full register word
  localparam SRC_WIDTH = 32;

  // Writable bits of a register; zero for unmapped or read-only words
  function [31:0] impl_mask;
    input [31:0] addr;
    begin
      case (addr)
        `ILS_ADDR_STAT_LINE_SEL: impl_mask = `ILS_STAT_SEL_MASK;
        `ILS_ADDR_ERR_LINE_SEL: impl_mask = `ILS_ERR_MASK;
        `ILS_ADDR_ERR_EN_SET: impl_mask = `ILS_ERR_MASK;
        `ILS_ADDR_ERR_EN_RESET: impl_mask = `ILS_ERR_MASK;
        `ILS_ADDR_EVT_ENABLE: impl_mask = `ILS_EVT_MASK;
        `ILS_ADDR_EVT_CLEAR: impl_mask = `ILS_EVT_MASK;
        default: impl_mask = 32'h00000000;
      endcase
    end
  endfunction

  // True for any address this block answers
  function is_mapped;
    input [31:0] addr;
    begin
      is_mapped = (impl_mask(addr) != 32'h00000000) ||
        (addr == `ILS_ADDR_EVT_STATUS);
    end
  endfunction

  // Valid transfer in its address phase
  assign addr_phase = HSEL & HTRANS[1] & HREADY;

  // Address phase split by direction
  assign wr_phase = addr_phase & HWRITE;
  assign rd_phase = addr_phase & ~HWRITE;

  // Flag a write whose data phase follows
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_phase;
    end
  end

  // Hold the write address for that data phase
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_addr_reg <= 32'h00000000;
    end else if (wr_phase) begin
      wr_addr_reg <= HADDR;
    end
  end

  // Register update from the write data phase
  always @* begin
    stat_sel_next = stat_sel_reg;
    err_sel_next = err_sel_reg;
    err_en_next = err_en_reg;
    evt_enable_next = evt_enable_reg;
    evt_clr = 32'h00000000;
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        `ILS_ADDR_STAT_LINE_SEL: begin
          stat_sel_next = HWDATA & `ILS_STAT_SEL_MASK; // RULE_04
        end
        `ILS_ADDR_ERR_LINE_SEL: begin
          err_sel_next = HWDATA & `ILS_ERR_MASK; // RULE_13
        end
        `ILS_ADDR_ERR_EN_SET: begin
          err_en_next = err_en_reg | (HWDATA & `ILS_ERR_MASK); // RULE_08
        end
        `ILS_ADDR_ERR_EN_RESET: begin
          err_en_next = err_en_reg & ~(HWDATA & `ILS_ERR_MASK); // RULE_12
        end
        `ILS_ADDR_EVT_ENABLE: begin
          evt_enable_next = HWDATA & `ILS_EVT_MASK;
        end
        `ILS_ADDR_EVT_CLEAR: begin
          evt_clr = HWDATA & `ILS_EVT_MASK;
        end
        default: begin
          evt_clr = 32'h00000000;
        end
      endcase
    end
  end

  // Block events seen this cycle
  always @* begin
    evt_set = 32'h00000000;
    evt_set[`ILS_EVT_UNMAPPED] = addr_phase & ~is_mapped(HADDR);
    evt_set[`ILS_EVT_RESERVED_WRITE] = wr_pend_reg & is_mapped(wr_addr_reg) &
      (|(HWDATA & ~impl_mask(wr_addr_reg))); // RULE_06
  end

  // Sticky event bits, a new event wins over a clear in the same cycle
  always @* begin
    evt_status_next = (evt_status_reg & ~evt_clr) | evt_set;
  end

  // Read data from next values so a read right after a write sees it
  always @* begin
    rd_next = 32'h00000000;
    case (HADDR)
      `ILS_ADDR_STAT_LINE_SEL: rd_next = stat_sel_next & `ILS_STAT_SEL_MASK; // RULE_05
      `ILS_ADDR_ERR_LINE_SEL: rd_next = err_sel_next & `ILS_ERR_MASK;
      `ILS_ADDR_ERR_EN_SET: rd_next = err_en_next & `ILS_ERR_MASK; // RULE_09
      `ILS_ADDR_ERR_EN_RESET: rd_next = err_en_next & `ILS_ERR_MASK; // RULE_12
      `ILS_ADDR_EVT_STATUS: rd_next = evt_status_next & `ILS_EVT_MASK;
      `ILS_ADDR_EVT_ENABLE: rd_next = evt_enable_next & `ILS_EVT_MASK;
      default: rd_next = 32'h00000000;
    endcase
  end

  // Status line selects, all sources start on output one
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      stat_sel_reg <= `ILS_STAT_SEL_RESET; // RULE_03
    end else begin
      stat_sel_reg <= stat_sel_next;
    end
  end

  // Error line selects, all sources start on output zero
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      err_sel_reg <= `ILS_ERR_SEL_RESET;
    end else begin
      err_sel_reg <= err_sel_next;
    end
  end

  // Error enables shared by the set and reset registers
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      err_en_reg <= `ILS_ERR_EN_RESET_VAL; // RULE_11
    end else begin
      err_en_reg <= err_en_next;
    end
  end

  // Sticky block event status
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      evt_status_reg <= `ILS_EVT_RESET;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  // Block event enables
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      evt_enable_reg <= `ILS_EVT_RESET;
    end else begin
      evt_enable_reg <= evt_enable_next;
    end
  end

  // Bus handshake: zero wait states, always OKAY
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= `ILS_HRESP_OKAY;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= `ILS_HRESP_OKAY;
    end
  end

  // Read data for one data phase, zero otherwise
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      HRDATA <= 32'h00000000;
    end else if (rd_phase) begin
      HRDATA <= rd_next;
    end else begin
      HRDATA <= 32'h00000000;
    end
  end

  // Reserved flag positions never reach the routers
  assign stat_flags_impl = STATUS_IRQ_FLAGS & `ILS_STAT_SEL_MASK; // RULE_04
  assign err_flags_impl = ERROR_IRQ_FLAGS & `ILS_ERR_MASK; // RULE_10

  // Status sources steered by their line select bits
  ils_line_router #(
    .WIDTH(SRC_WIDTH)
  ) u_stat_router (
    .flags(stat_flags_impl),
    .enables(STATUS_IRQ_ENABLES),
    .line_sel(stat_sel_reg),
    .hit_zero(stat_hit_zero),
    .hit_one(stat_hit_one)
  );

  // Error sources gated by enables and steered by their select bits
  ils_line_router #(
    .WIDTH(SRC_WIDTH)
  ) u_err_router (
    .flags(err_flags_impl),
    .enables(err_en_reg),
    .line_sel(err_sel_reg),
    .hit_zero(err_hit_zero),
    .hit_one(err_hit_one)
  );

  // Output zero from both routers
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ_OUT_ZERO <= 1'b0;
    end else begin
      IRQ_OUT_ZERO <= stat_hit_zero | err_hit_zero; // RULE_14
    end
  end

  // Output one from both routers
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ_OUT_ONE <= 1'b0;
    end else begin
      IRQ_OUT_ONE <= stat_hit_one | err_hit_one; // RULE_01
    end
  end

  // Block event line, high while an enabled event is pending
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      BLOCK_IRQ <= 1'b0;
    end else begin
      BLOCK_IRQ <= |(evt_status_reg & evt_enable_reg);
    end
  end

endmodule

`default_nettype wire

// ---- ils_irq_line_select_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module ils_irq_line_select_sva (
  input wire CLOCK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [31:0] STATUS_IRQ_FLAGS,
  input wire [31:0] STATUS_IRQ_ENABLES,
  input wire [31:0] ERROR_IRQ_FLAGS,
  input wire IRQ_OUT_ZERO,
  input wire IRQ_OUT_ONE,
  input wire BLOCK_IRQ
);
  // Read address phase and live status cause
  wire rd = HSEL && HTRANS[1] && !HWRITE && HREADY;
  wire act = |(STATUS_IRQ_FLAGS & STATUS_IRQ_ENABLES & 32'h0303ffff);
  wire cause = act || (|ERROR_IRQ_FLAGS);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Bus answer, read data and interrupt output relations
  AST_OKAY: assert property (HRESP == 1'b0) else $error("response not okay");
  AST_READY: assert property (HREADYOUT) else $error("wait state seen");
  AST_IDLE_DATA: assert property (!$past(rd) |-> HRDATA == 32'h0)
    else $error("read data outside data phase");
  AST_RSVD: assert property (HRDATA[31:27] == 5'h0 && HRDATA[23:19] == 5'h0)
    else $error("reserved bits read nonzero");
  AST_RST_IRQ: assert property ($past(SYS_RST) |-> !IRQ_OUT_ZERO && !IRQ_OUT_ONE && !BLOCK_IRQ)
    else $error("interrupt high after reset");
  AST_ROUTE: assert property ($past(act && !SYS_RST) |-> IRQ_OUT_ZERO || IRQ_OUT_ONE)
    else $error("enabled status flag on no line");
  AST_QUIET: assert property (!$past(cause) |-> !IRQ_OUT_ZERO && !IRQ_OUT_ONE)
    else $error("interrupt without cause");
  AST_CAUSE: assert property ($rose(IRQ_OUT_ZERO) || $rose(IRQ_OUT_ONE) |-> $past(cause))
    else $error("interrupt rose without flag");
  // Main scenarios
  cover property (IRQ_OUT_ZERO);
  cover property (IRQ_OUT_ONE);
  cover property (BLOCK_IRQ);
endmodule
bind ils_irq_line_select ils_irq_line_select_sva sva_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STATUS_IRQ_FLAGS(STATUS_IRQ_FLAGS),
  .STATUS_IRQ_ENABLES(STATUS_IRQ_ENABLES), .ERROR_IRQ_FLAGS(ERROR_IRQ_FLAGS),
  .IRQ_OUT_ZERO(IRQ_OUT_ZERO), .IRQ_OUT_ONE(IRQ_OUT_ONE), .BLOCK_IRQ(BLOCK_IRQ));
`default_nettype wire

// ---- ils_flag_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module ils_flag_src (
  input wire CLOCK,
  output var logic [31:0] st_flags,
  output var logic [31:0] st_enables,
  output var logic [31:0] er_flags
);
  // Flag levels start quiet
  initial begin
    st_flags = 32'h0;
    st_enables = 32'h0;
    er_flags = 32'h0;
  end
  // New levels land just after a rising edge
  task put(input logic [31:0] f, e, r);
    @(posedge CLOCK);
    st_flags <= f;
    st_enables <= e;
    er_flags <= r;
  endtask
endmodule
`default_nettype wire

// ---- tb_ils_irq_line_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ils_consts.vh"
module tb_ils_irq_line_select;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  wire [31:0] hrdata, sflg, senb, eflg;
  wire hready, hresp, irq0, irq1, birq;
  int n_mismatch = 0;
  int total_checks = 0;
  ils_flag_src flg_u (.CLOCK(clk), .st_flags(sflg), .st_enables(senb), .er_flags(eflg));
  ils_irq_line_select dut_u (.CLOCK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .STATUS_IRQ_FLAGS(sflg),
    .STATUS_IRQ_ENABLES(senb), .ERROR_IRQ_FLAGS(eflg), .IRQ_OUT_ZERO(irq0),
    .IRQ_OUT_ONE(irq1), .BLOCK_IRQ(birq));
  // 50 MHz clock
  initial forever #10 clk = ~clk;
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk_w(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_b(input logic got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t line %b expected %b", $time, got, exp);
    end
  endtask
  // One single transfer: address phase, then data phase
  task bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    chk_w(q, exp);
    chk_b(hresp, `ILS_HRESP_OKAY);
  endtask
  // Interrupt lines follow one edge later
  task settle;
    repeat (2) @(posedge clk);
  endtask
  task t_reset;
    rd(`ILS_ADDR_STAT_LINE_SEL, `ILS_STAT_SEL_RESET);
    rd(`ILS_ADDR_ERR_EN_SET, `ILS_ERR_EN_RESET_VAL);
    chk_b(irq0 | irq1, 1'b0);
    $display("test reset done");
  endtask
  task t_enable;
    wr(`ILS_ADDR_ERR_EN_SET, 32'h00000005);
    wr(`ILS_ADDR_ERR_EN_SET, 32'h07070ff0);
    rd(`ILS_ADDR_ERR_EN_SET, 32'h07070ff5);
    wr(`ILS_ADDR_ERR_EN_RESET, 32'h07070ff1);
    rd(`ILS_ADDR_ERR_EN_SET, 32'h00000004);
    wr(`ILS_ADDR_ERR_EN_SET, 32'hffffffff);
    rd(`ILS_ADDR_ERR_EN_SET, `ILS_ERR_MASK);
    wr(`ILS_ADDR_ERR_EN_RESET, `ILS_ERR_MASK);
    $display("test enable done");
  endtask
  task t_route;
    int p[6];
    logic [31:0] sel;
    p = '{0, 15, 16, 17, 24, 25};
    sel = 32'h02018000;
    wr(`ILS_ADDR_STAT_LINE_SEL, 32'hffffffff);
    rd(`ILS_ADDR_STAT_LINE_SEL, `ILS_STAT_SEL_MASK);
    wr(`ILS_ADDR_STAT_LINE_SEL, sel);
    foreach (p[i]) begin
      flg_u.put(32'h1 << p[i], 32'h1 << p[i], 32'h0);
      settle;
      chk_b(irq1, sel[p[i]]);
      chk_b(irq0, !sel[p[i]]);
      flg_u.put(32'h1 << p[i], 32'h0, 32'h0);
      settle;
      chk_b(irq0 | irq1, 1'b0);
    end
    $display("test route done");
  endtask
  task t_err;
    flg_u.put(32'h0, 32'h0, 32'h04000000);
    settle;
    chk_b(irq0 | irq1, 1'b0);
    wr(`ILS_ADDR_ERR_EN_SET, 32'h04000000);
    settle;
    chk_b(irq0, 1'b1);
    wr(`ILS_ADDR_ERR_LINE_SEL, 32'h04000000);
    settle;
    chk_b(irq1, 1'b1);
    chk_b(irq0, 1'b0);
    wr(`ILS_ADDR_ERR_EN_RESET, 32'h04000000);
    settle;
    chk_b(irq1, 1'b0);
    flg_u.put(32'h0, 32'h0, 32'h0);
    $display("test error done");
  endtask
  // Unmapped access raises a masked, then enabled, then cleared event
  task t_evt;
    wr(`ILS_ADDR_EVT_CLEAR, `ILS_EVT_MASK);
    rd(32'hffbff000, 32'h0);
    rd(`ILS_ADDR_EVT_STATUS, 32'h1);
    chk_b(birq, 1'b0);
    wr(`ILS_ADDR_EVT_ENABLE, 32'h1);
    settle;
    chk_b(birq, 1'b1);
    wr(`ILS_ADDR_EVT_CLEAR, 32'h1);
    settle;
    chk_b(birq, 1'b0);
    rd(`ILS_ADDR_EVT_STATUS, 32'h0);
    wr(`ILS_ADDR_EVT_CLEAR, 32'h00000006);
    rd(`ILS_ADDR_EVT_STATUS, 32'h2);
    wr(`ILS_ADDR_EVT_CLEAR, 32'h2);
    rd(`ILS_ADDR_EVT_STATUS, 32'h0);
    $display("test event done");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_enable;
    t_route;
    t_err;
    t_evt;
    complete_run;
  end
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    complete_run;
  end
endmodule
`default_nettype wire
